/* File: pkg/pfr_params.svh */
// offsets, field positions and reset values of the fault recorder
`ifndef PFR_PARAMS_SVH
`define PFR_PARAMS_SVH

// register byte offsets on the apb bus
`define PFR_OFF_ADDR     12'h000
`define PFR_OFF_STATUS   12'h004
`define PFR_OFF_COMMAND  12'h008
`define PFR_OFF_IRQ_STAT 12'h00c
`define PFR_OFF_IRQ_MASK 12'h010

// status word field positions
`define PFR_FID_LSB      9
`define PFR_FID_MSB      12
`define PFR_FLAG_MSB     5
`define PFR_SUP_LSB      3

// command word field position
`define PFR_CLR_BIT      0

// interrupt event positions
`define PFR_EV_RECORDED  0
`define PFR_EV_LOST      1

// reset values
`define PFR_ADDR_RST     32'h0000_0000
`define PFR_FLAGS_RST    6'h00
`define PFR_FID_RST      4'h0
`define PFR_IRQ_RST      2'h0

`endif

/* File: pkg/pfr_pkg.sv */
// types shared by the fault recorder
package pfr_pkg;

    // kind of access a bus master requests
    typedef enum logic [1:0] {
        PFR_ACC_READ  = 2'b00,
        PFR_ACC_WRITE = 2'b01,
        PFR_ACC_EXEC  = 2'b10,
        PFR_ACC_BAD   = 2'b11
    } pfr_acc_kind_t;

    // six violation flags, bit 5 supervisor read down to bit 0 user execute
    typedef logic [5:0] pfr_flags_t;

    // privilege identifier of a requestor
    typedef logic [3:0] pfr_priv_id_t;

endpackage

/* File: verilog/pfr_fault_recorder.sv */
// protection fault recorder with apb register access and interrupt
//
// What this block does
// [R01] capture full 32-bit faulting address on violation
// [R02] address register read-only, cleared only by command
// [R03] writing clear bit 1 erases fault address
// [R04] writing clear bit 1 clears flags and identifier
// [R05] store requestor privilege id in bits 12:9
// [R06] identifier meaningful only while a flag set
// [R07] supervisor read without permission sets bit 5
// [R08] supervisor write without permission sets bit 4
// [R09] supervisor execute without permission sets bit 3
// [R10] user read without permission sets bit 2
// [R11] user write without permission sets bit 1
// [R12] user execute without permission sets bit 0
// [R13] writing clear bit 0 changes nothing
// [R14] first fault held; reserved bits read zero
`include "pfr_params.svh"

module pfr_fault_recorder (
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // access request from a bus master, with the page permissions it meets
    input  wire logic                    acc_valid,
    input  wire logic [31:0]             acc_addr,
    input  wire logic [3:0]              acc_priv_id,
    input  wire logic                    acc_supervisor,
    input  wire pfr_pkg::pfr_acc_kind_t  acc_kind,
    input  wire logic [5:0]              acc_perm,
    // interrupt
    output logic                         irq
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [31:0]          fault_addr_r;
    pfr_pkg::pfr_flags_t  flags_r;
    pfr_pkg::pfr_priv_id_t fid_r;
    logic [1:0]           irq_stat_r;
    logic [1:0]           irq_mask_r;
    logic [31:0]          prdata_r;
    logic [31:0]          rdata_nxt;
    logic [2:0]           kind_oh;
    pfr_pkg::pfr_flags_t  err_hit;
    logic                 any_hit;
    logic                 any_flag;
    logic                 setup_ph;
    logic                 access_ph;
    logic                 addr_hit;
    logic                 clr_wr;
    logic                 rec_now;
    logic [1:0]           irq_ev;
    logic                 irq_rd_clr;
    logic [31:0]          status_word;

    ////////////////////////////////////////////////////////////////////////////
    // violation detection

    // one-hot kind, ordered read, write, execute to match the flag layout
    always_comb begin
        unique case (acc_kind)
            pfr_pkg::PFR_ACC_READ:  kind_oh = 3'h4;
            pfr_pkg::PFR_ACC_WRITE: kind_oh = 3'h2;
            pfr_pkg::PFR_ACC_EXEC:  kind_oh = 3'h1;
            default:                kind_oh = 3'h0;
        endcase
    end

    // each flag fires when its level and kind match and its permission is off
    genvar gi;
    generate
        for (gi = 0; gi <= `PFR_FLAG_MSB; gi++) begin : g_flag
            localparam bit IS_SUP = (gi >= `PFR_SUP_LSB);
            assign err_hit[gi] = acc_valid & (acc_supervisor == IS_SUP)
                                 & kind_oh[gi % 3] & ~acc_perm[gi]; // R07 R08 R09 R10 R11 R12
        end
    endgenerate

    assign any_hit  = |err_hit;
    assign any_flag = |flags_r;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    // zero wait states: every access phase completes at once
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign pready    = 1'b1;
    assign pslverr   = access_ph & ~addr_hit;

    // known register offsets
    always_comb begin
        unique case (paddr)
            `PFR_OFF_ADDR, `PFR_OFF_STATUS, `PFR_OFF_COMMAND,
            `PFR_OFF_IRQ_STAT, `PFR_OFF_IRQ_MASK: addr_hit = 1'b1;
            default:                              addr_hit = 1'b0;
        endcase
    end

    // a clear takes effect only when the written clear bit is one
    assign clr_wr = access_ph & pwrite & (paddr == `PFR_OFF_COMMAND)
                    & pwdata[`PFR_CLR_BIT]; // R03 R04 R13

    // a new fault is taken only when nothing is held or the record is being cleared
    // a fault hitting a held record only raises the lost event
    assign rec_now = any_hit & (~any_flag | clr_wr); // R14

    ////////////////////////////////////////////////////////////////////////////
    // fault record

    // faulting address: loaded on a new fault, zeroed by the clear command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_addr_r <= `PFR_ADDR_RST;
        end else if (rec_now) begin
            fault_addr_r <= acc_addr; // R01
        end else if (clr_wr) begin
            fault_addr_r <= `PFR_ADDR_RST; // R02 R03
        end
    end

    // flags and faulting id: a fault arriving with the clear wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= `PFR_FLAGS_RST;
            fid_r   <= `PFR_FID_RST;
        end else if (rec_now) begin
            flags_r <= err_hit;
            fid_r   <= acc_priv_id; // R05
        end else if (clr_wr) begin
            flags_r <= `PFR_FLAGS_RST; // R04
            fid_r   <= `PFR_FID_RST; // R04
        end
    end

    // status word; reserved bits are zero, id shown only beside a flag
    always_comb begin
        status_word = 32'h0000_0000; // R14
        status_word[`PFR_FLAG_MSB:0] = flags_r;
        status_word[`PFR_FID_MSB:`PFR_FID_LSB] = any_flag ? fid_r : 4'h0; // R06
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask

    assign irq_ev[`PFR_EV_RECORDED] = rec_now;
    assign irq_ev[`PFR_EV_LOST]     = any_hit & ~rec_now;
    assign irq_rd_clr = access_ph & ~pwrite & (paddr == `PFR_OFF_IRQ_STAT);

    // sticky events; a read clears only the bits it returned, so an event landing
    // between the setup and access phases of that read is not lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= `PFR_IRQ_RST;
        end else begin
            irq_stat_r <= (irq_rd_clr ? irq_stat_r & ~prdata_r[1:0] : irq_stat_r) | irq_ev;
        end
    end

    // mask, one enables the matching event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= `PFR_IRQ_RST;
        end else if (access_ph && pwrite && paddr == `PFR_OFF_IRQ_MASK) begin
            irq_mask_r <= pwdata[1:0];
        end
    end

    // level interrupt while any enabled event is pending
    assign irq = |(irq_stat_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // read data, sampled in the setup phase so it is steady in the access phase

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (paddr)
            `PFR_OFF_ADDR:     rdata_nxt = fault_addr_r;
            `PFR_OFF_STATUS:   rdata_nxt = status_word;
            `PFR_OFF_IRQ_STAT: rdata_nxt = {30'h0, irq_stat_r};
            `PFR_OFF_IRQ_MASK: rdata_nxt = {30'h0, irq_mask_r};
            default:           rdata_nxt = 32'h0000_0000;
        endcase
    end

    // hold read data for the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            prdata_r <= rdata_nxt;
        end
    end

    assign prdata = prdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_clear_alone;
        clr_wr && !any_hit;
    endsequence

    sequence s_zero_write;
        access_ph && pwrite && paddr == `PFR_OFF_COMMAND && !pwdata[`PFR_CLR_BIT];
    endsequence

    sequence s_quiet;
        !any_hit && !clr_wr;
    endsequence

    a_addr_capture: assert property ( // R01
        rec_now |=> fault_addr_r == $past(acc_addr))
        else $error("fault address not captured");

    a_addr_hold: assert property ( // R02
        s_quiet |=> $stable(fault_addr_r))
        else $error("fault address changed without fault or clear");

    a_clear_addr: assert property ( // R03
        s_clear_alone |=> fault_addr_r == 32'h0000_0000)
        else $error("clear did not erase fault address");

    a_clear_status: assert property ( // R04
        s_clear_alone |=> flags_r == 6'h00 && fid_r == 4'h0)
        else $error("clear did not erase fault status");

    a_fid_capture: assert property ( // R05
        rec_now |=> status_word[12:9] == $past(acc_priv_id))
        else $error("privilege id not captured");

    a_fid_valid: assert property ( // R06
        status_word[12:9] != 4'h0 |-> status_word[5:0] != 6'h00)
        else $error("id shown without a flag");

    a_flag_map: assert property ( // R07 supervisor read
        acc_valid && acc_supervisor && acc_kind == pfr_pkg::PFR_ACC_READ
        && !acc_perm[5] && !any_flag |=> flags_r[5] && status_word[5])
        else $error("supervisor read fault not flagged");

    a_user_exec: assert property ( // R12
        acc_valid && !acc_supervisor && acc_kind == pfr_pkg::PFR_ACC_EXEC
        && !acc_perm[0] && !any_flag |=> flags_r == 6'h01)
        else $error("user execute fault flagged wrongly");

    a_zero_write: assert property ( // R13
        s_zero_write and s_quiet |=> $stable(flags_r) && $stable(fault_addr_r))
        else $error("write of zero changed the record");

    a_first_kept: assert property ( // R14
        any_flag && !clr_wr |=> $stable(flags_r) && $stable(fid_r))
        else $error("held fault overwritten");

    a_rsvd_zero: assert property ( // R14
        status_word[31:13] == 19'h0 && status_word[8:6] == 3'h0)
        else $error("reserved status bits not zero");

    a_irq_level: assert property (
        rec_now && irq_mask_r[0] |=> ##[0:1] irq)
        else $error("interrupt not raised for recorded fault");

    // a fault meeting a held record, with no clear beside it
    sequence s_held_hit;
        any_flag && any_hit && !clr_wr;
    endsequence

    a_lost_event: assert property ( // R14
        s_held_hit |=> irq_stat_r[`PFR_EV_LOST])
        else $error("lost fault not reported");

    // a clear and a new fault on one edge: the fault stays
    a_set_wins: assert property ( // R04
        clr_wr && any_hit |=> flags_r == $past(err_hit) && fid_r == $past(acc_priv_id))
        else $error("clear beat a new fault");

    // a status read clears exactly what it returned
    a_irq_rd_clear: assert property (
        irq_rd_clr && !any_hit |=> (irq_stat_r & $past(prdata_r[1:0])) == 2'h0)
        else $error("read did not clear returned events");

    // read data is taken in setup and must match the register in access
    a_read_addr: assert property ( // R01
        setup_ph && !pwrite && paddr == `PFR_OFF_ADDR && !any_hit
        |=> prdata == fault_addr_r)
        else $error("read data differs from fault address");

endmodule

/* File: dv/pfr_req_master.sv */
// bus master model issuing privilege-tagged access requests
module pfr_req_master (
    // clock
    input  wire logic              pclk,
    // access request
    output logic                   acc_valid,
    output logic [31:0]            acc_addr,
    output logic [3:0]             acc_priv_id,
    output logic                   acc_supervisor,
    output pfr_pkg::pfr_acc_kind_t acc_kind,
    output logic [5:0]             acc_perm
);
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////////
    // idle lines at time zero
    initial begin
        acc_valid = 1'b0;
        acc_addr = 32'h0;
        acc_priv_id = 4'h0;
        acc_supervisor = 1'b0;
        acc_kind = pfr_pkg::PFR_ACC_BAD;
        acc_perm = 6'h3f;
    end

    // one request for one cycle, then lines show the inverse of the last value
    task send(input logic [31:0] a, input logic [3:0] id, input logic s,
              input pfr_pkg::pfr_acc_kind_t k, input logic [5:0] p);
        @(posedge pclk);
        acc_valid <= 1'b1;
        acc_addr <= a;
        acc_priv_id <= id;
        acc_supervisor <= s;
        acc_kind <= k;
        acc_perm <= p;
        @(posedge pclk);
        acc_valid <= 1'b0;
        acc_addr <= ~a;
        acc_priv_id <= ~id;
        acc_supervisor <= ~s;
        acc_kind <= pfr_pkg::pfr_acc_kind_t'(~k);
        acc_perm <= ~p;
    endtask
endmodule

/* File: dv/tb.sv */
// self-checking bench for the protection fault recorder
`include "pfr_params.svh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0]            paddr;
    logic [31:0]            pwdata, prdata, rd, seed, m_addr, a;
    logic                   acc_valid, acc_supervisor, err;
    logic [31:0]            acc_addr;
    logic [3:0]             acc_priv_id, m_fid, id;
    logic [5:0]             acc_perm, m_flags, bit_m;
    logic [1:0]             m_ist, m_mask;
    pfr_pkg::pfr_acc_kind_t acc_kind, k;
    int                     miscompares, n_tests, cyc;

    pfr_fault_recorder DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_priv_id(acc_priv_id), .acc_supervisor(acc_supervisor), .acc_kind(acc_kind),
        .acc_perm(acc_perm), .irq(irq));
    pfr_req_master MST (.pclk(pclk), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_priv_id(acc_priv_id), .acc_supervisor(acc_supervisor), .acc_kind(acc_kind),
        .acc_perm(acc_perm));

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            miscompares++;
            close_out();
        end
    end

    // xorshift source
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // one apb transfer, waits for pready
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // compare irq, address and status with the model
    task chk_regs();
        @(negedge pclk);
        `CHK("irq", |(m_ist & m_mask), irq)
        `CHK("pready", 1'b1, pready)
        apb(1'b0, `PFR_OFF_ADDR, 32'h0, rd, err);
        `CHK("fault_addr", m_addr, rd)
        `CHK("slverr", 1'b0, err)
        apb(1'b0, `PFR_OFF_STATUS, 32'h0, rd, err);
        `CHK("status", {19'h0, (m_flags != 6'h0) ? m_fid : 4'h0, 3'h0, m_flags}, rd)
        `CHK("flags", m_flags, rd[5:0])
    endtask

    task close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {m_addr, m_fid, m_flags, m_ist, m_mask} = '0;
        seed = 32'h01bc986e;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk_regs();
        apb(1'b0, `PFR_OFF_COMMAND, 32'h0, rd, err);
        `CHK("command", 32'h0, rd)
        apb(1'b0, 12'h0f0, 32'h0, rd, err);
        `CHK("unmapped", 1'b1, err)
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            m_mask = 2'(xs() | (i == 0));
            apb(1'b1, `PFR_OFF_IRQ_MASK, {30'h0, m_mask}, rd, err);
            k = pfr_pkg::pfr_acc_kind_t'(2'(2 - i % 3));
            bit_m = 6'h1 << i;
            MST.send(xs(), 4'(xs()), i >= 3, k, 6'(xs()) | bit_m);
            MST.send(xs(), 4'(xs()), i >= 3, pfr_pkg::PFR_ACC_BAD, 6'h0);
            a = xs();
            id = 4'(xs());
            MST.send(a, id, i >= 3, k, 6'(xs()) & ~bit_m);
            {m_addr, m_fid, m_flags} = {a, id, bit_m};
            m_ist[0] = 1'b1;
            MST.send(~a, ~id, i >= 3, k, 6'h0);
            m_ist[1] = 1'b1;
            chk_regs();
            apb(1'b1, `PFR_OFF_ADDR, xs(), rd, err);
            apb(1'b1, `PFR_OFF_COMMAND, 32'hfffffffe, rd, err);
            chk_regs();
            apb(1'b0, `PFR_OFF_IRQ_STAT, 32'h0, rd, err);
            `CHK("irq_stat", {30'h0, m_ist}, rd)
            m_ist = 2'h0;
            apb(1'b1, `PFR_OFF_COMMAND, 32'h1, rd, err);
            {m_addr, m_fid, m_flags} = '0;
            chk_regs();
            $display("test violation %0d done", i);
        end
        // a clear and a new fault on one edge, over a held record
        a = xs();
        MST.send(~a, 4'h3, 1'b1, pfr_pkg::PFR_ACC_WRITE, 6'h2f);
        fork
            apb(1'b1, `PFR_OFF_COMMAND, 32'h1, rd, err);
            begin
                @(posedge pclk);
                MST.send(a, 4'h9, 1'b0, pfr_pkg::PFR_ACC_READ, 6'h3b);
            end
        join
        {m_addr, m_fid, m_flags} = {a, 4'h9, 6'h04};
        m_ist[0] = 1'b1;
        chk_regs();
        // reset in mid-run drops the record and the events
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        {m_addr, m_fid, m_flags, m_ist, m_mask} = '0;
        chk_regs();
        $display("test set wins and reset done");
        close_out();
    end
endmodule
